// File: design/eep_pkg.sv
package eep_pkg;
  // ****************************************
  // Select byte and addressing
  // ****************************************
  localparam logic [3:0] EEP_TYPE_ID = 4'h6; // Arbitrary type code
  localparam int EEP_TYPE_MSB = 7;
  localparam int EEP_TYPE_LSB = 4;
  localparam int EEP_ZERO_BIT = 3;
  localparam int EEP_CS1_BIT = 2;
  localparam int EEP_CS0_BIT = 1;
  localparam int EEP_DIR_BIT = 0;
  localparam int EEP_ADDR_W = 15;
  localparam int EEP_PAGE_W = 6;
  localparam int EEP_MEM_DEPTH = 32768;
  localparam logic [3:0] EEP_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] EEP_ACK_SLOT = 4'h8;
  localparam logic [14:0] EEP_ADDR_RESET = 15'h0000;
  // ****************************************
  // Timing
  // ****************************************
  localparam int EEP_CLK_MHZ = 25;
  localparam int EEP_WRITE_CYCLE_TIME_US = 5;
  localparam int EEP_WRITE_CYCLES = EEP_WRITE_CYCLE_TIME_US * EEP_CLK_MHZ;
  // ****************************************
  // Protocol states
  // ****************************************
  typedef enum logic [6:0] {
    EEP_IDLE = 7'h01,
    EEP_SEL = 7'h02,
    EEP_ADDRH = 7'h04,
    EEP_ADDRL = 7'h08,
    EEP_WDATA = 7'h10,
    EEP_RDATA = 7'h20,
    EEP_BUSY = 7'h40
  } eep_state_t;
endpackage

// File: design/eep_line_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-stage synchroniser with edge and bus-condition detection
// ****************************************
module eep_line_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclRise,
  output logic sclFall,
  output logic sclLevel,
  output logic sdaLevel,
  output logic startSeen,
  output logic stopSeen
);
  logic [1:0] sclMeta_reg;
  logic [1:0] sdaMeta_reg;
  logic sclOld_reg;
  logic sdaOld_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      sclMeta_reg <= 2'h3;
      sdaMeta_reg <= 2'h3;
      sclOld_reg <= 1'b1;
      sdaOld_reg <= 1'b1;
    end else begin
      sclMeta_reg <= {sclMeta_reg[0], sclIn};
      sdaMeta_reg <= {sdaMeta_reg[0], sdaIn};
      sclOld_reg <= sclMeta_reg[1];
      sdaOld_reg <= sdaMeta_reg[1];
    end
  end

  assign sclLevel = sclMeta_reg[1];
  assign sdaLevel = sdaMeta_reg[1];
  assign sclRise = sclLevel & ~sclOld_reg;
  assign sclFall = ~sclLevel & sclOld_reg;
  // Conditions only count while the clock stays high across the data edge
  assign startSeen = sclLevel & sclOld_reg & sdaOld_reg & ~sdaLevel;
  assign stopSeen = sclLevel & sclOld_reg & ~sdaOld_reg & sdaLevel;
endmodule
`default_nettype wire

// File: design/eep_mem_array.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Byte array, one write port, one read port
// ****************************************
module eep_mem_array
  import eep_pkg::*;
(
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [EEP_ADDR_W-1:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [EEP_ADDR_W-1:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] cells [EEP_MEM_DEPTH];

  // No reset: contents are non-volatile in intent
  always_ff @(posedge clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  assign rdData = cells[rdAddr];
endmodule
`default_nettype wire

// File: design/eep_i2c_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE_01] Transmitter releases data line after eight bits
// [RULE_02] Receiver acknowledges by pulling low ninth
// [RULE_03] Data sampled on rising serial clock
// [RULE_04] Master sends select byte, MSB first
// [RULE_05] Upper select bits must equal type
// [RULE_06] Low select bits: zero, pin1, pin0
// [RULE_07] Direction bit: one read, zero write
// [RULE_08] Match acknowledges; mismatch returns to standby
// [RULE_09] Sixteen-bit address, high first, b15 ignored
// [RULE_10] Write select, two acknowledged address bytes
// [RULE_11] Guard high: no store, data not acknowledged
// [RULE_12] Byte write acknowledged only when unguarded
// [RULE_13] Page write: 64 bytes in one row
// [RULE_14] Only low six address bits increment
// [RULE_15] Write starts only on STOP after ack
// [RULE_16] Busy device ignores data line completely
// [RULE_17] Polling: no ack while busy, then ack
// [RULE_18] Reads independent of write guard
// [RULE_19] Random read: dummy write, restart, read
// [RULE_20] START/STOP are data edges, clock high
// [RULE_21] Current read uses counter, then increments
// [RULE_22] Acked reads continue, wrapping to zero
// [RULE_23] Read without ack returns to standby
// [RULE_24] Write cycle length is parameterised counter
// [RULE_25] One shared address counter for both
module eep_i2c_slave
  import eep_pkg::*;
#(
  parameter int WRITE_CYCLES = EEP_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic chip_select_pin0,
  input wire logic chip_select_pin1,
  input wire logic write_guard,
  output logic busy
);
  // ****************************************
  // Line sampling
  // ****************************************
  logic sclRise, sclFall, sclLevel, sdaLevel, startSeen, stopSeen;
  logic [1:0] guardMeta_reg;
  logic [1:0] cs0Meta_reg;
  logic [1:0] cs1Meta_reg;

  eep_line_sync u_sync (
    .clk(clk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .sclLevel(sclLevel),
    .sdaLevel(sdaLevel),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      guardMeta_reg <= 2'h0;
      cs0Meta_reg <= 2'h0;
      cs1Meta_reg <= 2'h0;
    end else begin
      guardMeta_reg <= {guardMeta_reg[0], write_guard};
      cs0Meta_reg <= {cs0Meta_reg[0], chip_select_pin0};
      cs1Meta_reg <= {cs1Meta_reg[0], chip_select_pin1};
    end
  end

  // ****************************************
  // Protocol state
  // ****************************************
  eep_state_t state_reg, state_next;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic inAck_reg;
  logic ackGiven_reg;
  logic guarded_reg;
  logic writeArmed_reg;
  logic dataAcked_reg;
  logic [EEP_ADDR_W-1:0] addr_reg;
  logic [EEP_ADDR_W-1:0] wrAddr_reg;
  logic [7:0] wrData_reg;
  logic wrEn_reg;
  logic [15:0] waitCnt_reg;
  logic sdaOut_reg, sdaOe_reg, busy_reg;
  logic [7:0] memRd;

  wire isBusy = state_reg == EEP_BUSY;
  wire byteDone = sclRise & ~inAck_reg & (bitCnt_reg == EEP_BITS_PER_BYTE - 4'h1);
  wire [7:0] byteIn = {shift_reg[6:0], sdaLevel};
  wire typeMatch = byteIn[EEP_TYPE_MSB:EEP_TYPE_LSB] == EEP_TYPE_ID; // RULE_05
  wire csMatch = ~byteIn[EEP_ZERO_BIT] & (byteIn[EEP_CS1_BIT] == cs1Meta_reg[1]) &
                 (byteIn[EEP_CS0_BIT] == cs0Meta_reg[1]); // RULE_06
  wire selMatch = typeMatch & csMatch;
  wire dirRead = byteIn[EEP_DIR_BIT]; // RULE_07
  wire guardNow = guarded_reg | guardMeta_reg[1];
  wire [EEP_ADDR_W-1:0] addrPageInc = {addr_reg[EEP_ADDR_W-1:EEP_PAGE_W],
                                        addr_reg[EEP_PAGE_W-1:0] + 6'h01}; // RULE_14
  wire [EEP_ADDR_W-1:0] addrLinInc = addr_reg + 15'h0001; // RULE_22
  wire waitDone = waitCnt_reg == 16'(WRITE_CYCLES - 1);
  // Ack slot ends on the falling edge after the ninth clock
  wire ackEnd = inAck_reg & sclFall;
  wire masterNack = inAck_reg & sclRise & sdaLevel & (state_reg == EEP_RDATA);

  eep_mem_array u_mem (
    .clk(clk),
    .wrEn(wrEn_reg),
    .wrAddr(wrAddr_reg),
    .wrData(wrData_reg),
    .rdAddr(addr_reg),
    .rdData(memRd)
  );

  // ****************************************
  // Next-state decode
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EEP_IDLE: state_next = EEP_IDLE;
      EEP_SEL: if (byteDone) begin
        state_next = selMatch ? (dirRead ? EEP_RDATA : EEP_ADDRH) : EEP_IDLE; // RULE_08
      end
      EEP_ADDRH: if (byteDone) begin
        state_next = EEP_ADDRL; // RULE_10
      end
      EEP_ADDRL: if (byteDone) begin
        state_next = EEP_WDATA;
      end
      EEP_WDATA: state_next = EEP_WDATA;
      EEP_RDATA: if (masterNack) begin
        state_next = EEP_IDLE; // RULE_23
      end
      EEP_BUSY: if (waitDone) begin
        state_next = EEP_IDLE;
      end
      default: state_next = EEP_IDLE;
    endcase
    if (!isBusy) begin
      if (startSeen) begin
        state_next = EEP_SEL; // RULE_20
      end else if (stopSeen) begin
        state_next = writeArmed_reg ? EEP_BUSY : EEP_IDLE; // RULE_15
      end
    end
  end

  // ****************************************
  // Bit engine
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= EEP_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      inAck_reg <= 1'b0;
      ackGiven_reg <= 1'b0;
      guarded_reg <= 1'b0;
      writeArmed_reg <= 1'b0;
      dataAcked_reg <= 1'b0;
      addr_reg <= EEP_ADDR_RESET;
      wrAddr_reg <= EEP_ADDR_RESET;
      wrData_reg <= 8'h00;
      wrEn_reg <= 1'b0;
      waitCnt_reg <= 16'h0000;
      sdaOut_reg <= 1'b0;
      sdaOe_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wrEn_reg <= 1'b0;
      busy_reg <= state_next == EEP_BUSY;
      waitCnt_reg <= isBusy ? waitCnt_reg + 16'h0001 : 16'h0000; // RULE_24
      if (isBusy) begin
        sdaOe_reg <= 1'b0; // RULE_16 RULE_17
        writeArmed_reg <= 1'b0;
      end else if (startSeen || stopSeen) begin
        bitCnt_reg <= 4'h0;
        inAck_reg <= 1'b0;
        sdaOe_reg <= 1'b0;
        if (startSeen) begin
          guarded_reg <= guardMeta_reg[1];
        end
        if (stopSeen) begin
          // Commit takes effect at the end of the write cycle in intent,
          // but storage is immediate; reads are blocked by busy anyway
          writeArmed_reg <= 1'b0;
        end
      end else begin
        if (state_reg == EEP_SEL || state_reg == EEP_ADDRH || state_reg == EEP_ADDRL) begin
          guarded_reg <= guardNow; // RULE_11
        end
        if (sclRise && !inAck_reg) begin
          shift_reg <= byteIn; // RULE_03 RULE_04
          bitCnt_reg <= bitCnt_reg + 4'h1;
        end
        // Only a completed bit disarms: the rise that opens a STOP must not
        if (sclFall && !inAck_reg) begin
          writeArmed_reg <= 1'b0; // RULE_15
        end
        if (byteDone) begin
          case (state_reg)
            EEP_ADDRH: addr_reg <= {byteIn[6:0], addr_reg[7:0]}; // RULE_09
            EEP_ADDRL: addr_reg <= {addr_reg[14:8], byteIn}; // RULE_25
            EEP_WDATA: if (!guardNow) begin
              wrEn_reg <= 1'b1; // RULE_13
              wrAddr_reg <= addr_reg;
              wrData_reg <= byteIn;
              addr_reg <= addrPageInc; // RULE_14
            end
            default: addr_reg <= addr_reg;
          endcase
          // The device never acknowledges its own read data
          ackGiven_reg <= (state_reg == EEP_SEL) ? selMatch :
                          (state_reg == EEP_WDATA) ? ~guardNow :
                          (state_reg == EEP_ADDRH || state_reg == EEP_ADDRL); // RULE_12
          dataAcked_reg <= state_reg == EEP_WDATA && !guardNow;
        end
        // Drive ack on the fall after the eighth rise, through the ninth clock
        if (sclFall && bitCnt_reg == EEP_ACK_SLOT && !inAck_reg) begin
          inAck_reg <= 1'b1;
          bitCnt_reg <= 4'h0;
          sdaOe_reg <= ackGiven_reg; // RULE_01 RULE_02 RULE_08 RULE_11
          sdaOut_reg <= 1'b0;
        end else if (ackEnd) begin
          inAck_reg <= 1'b0;
          // The low address ack also ends in the data state, so only a data ack arms
          writeArmed_reg <= dataAcked_reg; // RULE_15
          if (state_reg == EEP_RDATA) begin
            // First read byte after select, or next byte after master ack
            sdaOe_reg <= ~memRd[7]; // RULE_18 RULE_21
            sdaOut_reg <= 1'b0;
            shift_reg <= memRd;
            addr_reg <= addrLinInc; // RULE_21 RULE_22
          end else begin
            sdaOe_reg <= 1'b0; // RULE_01
          end
        end else if (sclFall && state_reg == EEP_RDATA && !inAck_reg) begin
          // Open-drain: enable pulls low for a zero bit
          // Each rise shifts left, so the next bit is always on top
          sdaOe_reg <= ~shift_reg[7]; // RULE_19
        end
        if (state_reg == EEP_IDLE && !inAck_reg) begin
          sdaOe_reg <= 1'b0; // RULE_08
        end
      end
    end
  end

  assign sdaOut = sdaOut_reg;
  assign sdaOe = sdaOe_reg;
  assign busy = busy_reg;

  // ****************************************
  // Checks
  // ****************************************
  property p_busy_quiet;
    @(posedge clk) disable iff (rst) isBusy |=> !sdaOe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy"); // RULE_16

  property p_out_low;
    @(posedge clk) disable iff (rst) sdaOe |-> !sdaOut;
  endproperty
  a_out_low: assert property (p_out_low) else $error("drove high"); // RULE_02

  property p_mismatch;
    @(posedge clk) disable iff (rst) (state_reg == EEP_SEL && byteDone && !selMatch && !startSeen && !stopSeen)
      |=> state_reg == EEP_IDLE;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not idle"); // RULE_08

  property p_no_write_guarded;
    @(posedge clk) disable iff (rst) (state_reg == EEP_WDATA && byteDone && guardNow) |=> !wrEn_reg;
  endproperty
  a_no_write_guarded: assert property (p_no_write_guarded) else $error("guarded write"); // RULE_11

  property p_page_row;
    @(posedge clk) disable iff (rst) wrEn_reg |-> addr_reg[14:6] == wrAddr_reg[14:6];
  endproperty
  a_page_row: assert property (p_page_row) else $error("row changed"); // RULE_14

  property p_stop_unarmed;
    @(posedge clk) disable iff (rst) (stopSeen && !writeArmed_reg && !isBusy) |=> state_reg == EEP_IDLE;
  endproperty
  a_stop_unarmed: assert property (p_stop_unarmed) else $error("spurious write"); // RULE_15

  property p_busy_len;
    @(posedge clk) disable iff (rst) $rose(isBusy) |-> isBusy [*8];
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short"); // RULE_24

  property p_nack_idle;
    @(posedge clk) disable iff (rst) (masterNack && !startSeen && !stopSeen) |=> state_reg == EEP_IDLE;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("read not ended"); // RULE_23

  c_write: cover property (@(posedge clk) disable iff (rst) wrEn_reg);
  c_busy: cover property (@(posedge clk) disable iff (rst) $rose(isBusy));
  c_read: cover property (@(posedge clk) disable iff (rst) state_reg == EEP_RDATA && ackEnd);
endmodule
`default_nettype wire

// File: verif/eep_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Behavioural two-wire bus master
// ****************************************
module eep_bus_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  // Serial clock idles high between frames; data line released to the pull-up
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Quarter of the 320 ns serial period, always ending on a falling clk edge
  task automatic q();
    repeat (2) @(negedge clk);
  endtask

  // Also serves as repeated start: data released while the clock is low
  task automatic start();
    sdaLow = 1'b0;
    q();
    scl = 1'b1;
    q();
    sdaLow = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask

  task automatic stop();
    sdaLow = 1'b1;
    q();
    scl = 1'b1;
    q();
    sdaLow = 1'b0;
    q();
    q();
  endtask

  task automatic bitx(input logic b, output logic o);
    sdaLow = !b;
    q();
    scl = 1'b1;
    q();
    o = sda;
    q();
    scl = 1'b0;
    q();
  endtask

  // Send d (all ones to read), then drive the ninth bit as given
  task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] r, output logic ninthIn);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r[i]);
    end
    bitx(ninth, ninthIn);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import eep_pkg::*;
;
  localparam logic [1:0] CS = 2'b10;
  localparam int CYCLE_LEN = 200;
  logic clk, rst, scl, sdaLow, sdaOut, sdaOe, writeGuard, busy;
  logic [7:0] rd;
  logic ak;
  logic [7:0] mdl [0:32767];
  int failures = 0;
  int totalChecks = 0;
  int tries;
  // Open-drain data line with pull-up
  wire logic sdaLine = !(sdaLow || (sdaOe && !sdaOut));

  eep_i2c_slave #(.WRITE_CYCLES(CYCLE_LEN)) i_eep_i2c_slave (
    .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .chip_select_pin0(CS[0]), .chip_select_pin1(CS[1]), .write_guard(writeGuard), .busy(busy)
  );
  eep_bus_master i_eep_bus_master (.clk(clk), .sda(sdaLine), .scl(scl), .sdaLow(sdaLow));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Checking and access tasks
  // ****************************************
  task automatic stop_test();
    $display("checks=%0d failures=%0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] selCode(input logic [1:0] cs, input logic dir);
    return {EEP_TYPE_ID, 1'b0, cs, dir};
  endfunction

  task automatic sendByte(input logic [7:0] d, input logic expAck);
    i_eep_bus_master.xfer(d, 1'b1, rd, ak);
    chk(16'(!ak), 16'(expAck));
  endtask

  // Write selection repeated until acknowledged; the bound cuts a dead device short
  task automatic poll();
    tries = 0;
    ak = 1'b1;
    while (ak && tries < 12) begin
      i_eep_bus_master.start();
      i_eep_bus_master.xfer(selCode(CS, 1'b0), 1'b1, rd, ak);
      tries++;
    end
    chk(16'(ak), 16'(0));
    if (ak) stop_test();
  endtask

  task automatic writeSeq(input logic [15:0] addr, input int n, input logic dataAck);
    poll();
    sendByte(addr[15:8], 1'b1);
    sendByte(addr[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      sendByte(8'(8'h30 + i), dataAck);
      if (dataAck) mdl[{addr[14:6], 6'(addr[5:0] + i)}] = 8'(8'h30 + i);
    end
    i_eep_bus_master.stop();
    repeat (8) @(negedge clk);
    chk(16'(busy), 16'(dataAck));
  endtask

  task automatic readSeq(input logic [15:0] addr, input int n, input logic random);
    if (random) begin
      poll();
      sendByte(addr[15:8], 1'b1);
      sendByte(addr[7:0], 1'b1);
    end
    i_eep_bus_master.start();
    sendByte(selCode(CS, 1'b1), 1'b1);
    for (int i = 0; i < n; i++) begin
      i_eep_bus_master.xfer(8'hFF, i == n - 1, rd, ak);
      chk(16'(rd), 16'(mdl[15'(addr + i)]));
    end
    i_eep_bus_master.stop();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    writeGuard = 1'b0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    // Every strap pattern, a wrong type field and a set zero bit
    for (int k = 0; k < 6; k++) begin
      i_eep_bus_master.start();
      sendByte(k < 4 ? selCode(2'(k), 1'b0) : selCode(CS, 1'b0) ^ (k == 4 ? 8'h80 : 8'h08),
               2'(k) == CS && k < 4);
      i_eep_bus_master.stop();
    end
    // Page overrun from column 62 with b15 set: wraps in row, counter ends at 0
    writeSeq(16'h803E, 66, 1'b1);
    poll();
    chk(16'(tries > 1), 16'(1));
    i_eep_bus_master.stop();
    repeat (8) @(negedge clk);
    chk(16'(busy), 16'(0));
    readSeq(16'h0000, 64, 1'b0);
    writeGuard = 1'b1;
    writeSeq(16'h0010, 1, 1'b0);
    readSeq(16'h0010, 1, 1'b1);
    writeGuard = 1'b0;
    writeSeq(16'h7FFF, 1, 1'b1);
    readSeq(16'h7FFF, 2, 1'b1);
    stop_test();
  end

  initial begin
    repeat (100000) @(negedge clk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
